/* design/rx_exit_ctrl.sv */
// Receive timeout, clear channel indication and after-packet state selection.
`timescale 1ns/100ps
// How it works
// - Carrier-sense end enabled: leave receive early when measured signal is below threshold.
// - Timeout equals wake period times 3.6058 scaled by resolution, halved per select.
// - Timeout select seven means no timeout; receive until packet end.
// - Clear channel: always, below threshold, not receiving, or both conditions.
// - Clear channel output always follows the currently selected mode.
// - After receive go idle, synth-on ready, transmit or stay receiving per field.
// - After transmit go idle, synth-on ready, stay transmitting or receive per field.
// - Stay-in-transmit restarts preamble immediately after the packet is sent.
module rx_exit_ctrl
  import rx_exit_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  input wire radio_in_t radio_in,
  input wire logic [15:0] wake_event_period,
  input wire logic [1:0] wake_poll_resolution,
  output logic clear_channel_indication_r,
  output radio_state_t next_state_r,
  output logic next_state_strobe_r,
  output logic rx_timeout_exit_r,
  output logic preamble_restart_r,
  output logic rx_timer_running_r
);
  logic [7:0] rx_timeout_config_r;
  logic [7:0] rx_timeout_config_nxt;
  logic [7:0] packet_exit_cca_config_r;
  logic [7:0] packet_exit_cca_config_nxt;
  logic [7:0] reg_rdata_nxt;
  logic [TIMER_W-1:0] timer_r;
  logic [TIMER_W-1:0] timer_nxt;
  logic [TIMER_W-1:0] limit_r;
  logic [TIMER_W-1:0] limit_nxt;
  logic [TIMER_W-1:0] limit_calc;
  logic rx_timer_running_nxt;
  logic clear_channel_nxt;
  radio_state_t next_state_nxt;
  logic next_state_strobe_nxt;
  logic rx_timeout_exit_nxt;
  logic preamble_restart_nxt;
  logic [2:0] rx_time_sel;
  logic [1:0] cca_sel;
  logic [1:0] after_rx;
  logic [1:0] after_tx;
  logic [3:0] res_mult;
  logic expired;
  logic keep_rx;

  assign rx_time_sel = rx_timeout_config_r[RX_TIME_LSB +: RX_TIME_W];
  assign cca_sel = packet_exit_cca_config_r[CCA_SEL_LSB +: 2];
  assign after_rx = packet_exit_cca_config_r[AFTER_RX_LSB +: 2];
  assign after_tx = packet_exit_cca_config_r[AFTER_TX_LSB +: 2];

  // Register writes keep only the defined bits; reads return config or live status.
  always_comb
  begin
    rx_timeout_config_nxt = rx_timeout_config_r;
    packet_exit_cca_config_nxt = packet_exit_cca_config_r;
    reg_rdata_nxt = reg_rdata_r;
    if (reg_wr && reg_addr == RX_TIMEOUT_CONFIG_OFS)
    begin
      rx_timeout_config_nxt = reg_wdata & RX_TIMEOUT_WMASK;
    end
    if (reg_wr && reg_addr == PACKET_EXIT_CCA_CONFIG_OFS)
    begin
      packet_exit_cca_config_nxt = reg_wdata & PACKET_EXIT_WMASK;
    end
    if (reg_rd)
    begin
      case (reg_addr)
        RX_TIMEOUT_CONFIG_OFS: reg_rdata_nxt = rx_timeout_config_r;
        PACKET_EXIT_CCA_CONFIG_OFS: reg_rdata_nxt = packet_exit_cca_config_r;
        EXIT_STATUS_OFS: reg_rdata_nxt = {5'h00, clear_channel_indication_r, next_state_r};
        default: reg_rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rx_timeout_config_r <= RX_TIMEOUT_CONFIG_RST;
      packet_exit_cca_config_r <= PACKET_EXIT_CCA_CONFIG_RST;
      reg_rdata_r <= 8'h00;
    end
    else
    begin
      rx_timeout_config_r <= rx_timeout_config_nxt;
      packet_exit_cca_config_r <= packet_exit_cca_config_nxt;
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  // Timeout length in cycles: period times resolution factor, halved per select step.
  always_comb
  begin
    case (wake_poll_resolution)
      2'h0: res_mult = RES_MULT_0;
      2'h1: res_mult = RES_MULT_1;
      2'h2: res_mult = RES_MULT_2;
      default: res_mult = RES_MULT_3;
    endcase
    limit_calc = (TIMER_W'(wake_event_period) * TIMER_W'(res_mult) * TIMER_W'(TIMEOUT_SCALE_Q))
                 >> (SCALE_SHIFT + int'(rx_time_sel));
    if (limit_calc < TIMER_ONE)
    begin
      limit_calc = TIMER_ONE;
    end
  end

  assign expired = rx_timer_running_r && rx_time_sel != RX_TIME_NONE && timer_r >= limit_r;
  // Qualifier clear needs sync; qualifier set accepts sync or preamble quality.
  assign keep_rx = radio_in.sync_found ||
                   (rx_timeout_config_r[RX_QUAL_BIT] && radio_in.preamble_quality);

  // Receive timer, exit decisions and after-packet state choice.
  always_comb
  begin
    timer_nxt = timer_r;
    limit_nxt = limit_r;
    rx_timer_running_nxt = rx_timer_running_r;
    next_state_nxt = next_state_r;
    next_state_strobe_nxt = 1'b0;
    rx_timeout_exit_nxt = 1'b0;
    preamble_restart_nxt = 1'b0;
    if (radio_in.rx_enter)
    begin
      timer_nxt = '0;
      limit_nxt = limit_calc;
      rx_timer_running_nxt = 1'b1;
    end
    else if (radio_in.rx_leave)
    begin
      rx_timer_running_nxt = 1'b0;
    end
    else if (radio_in.rx_packet_done)
    begin
      next_state_strobe_nxt = 1'b1;
      case (after_rx)
        2'h0: next_state_nxt = ST_IDLE;
        2'h1: next_state_nxt = ST_SYNTH_ON_TX_READY;
        2'h2: next_state_nxt = ST_TX;
        default: next_state_nxt = ST_RX;
      endcase
      rx_timer_running_nxt = (after_rx == 2'h3);
      timer_nxt = '0;
    end
    else if (rx_timer_running_r && rx_timeout_config_r[RX_END_CS_BIT] && radio_in.cs_valid &&
             !radio_in.carrier_sense)
    begin
      rx_timer_running_nxt = 1'b0;
      rx_timeout_exit_nxt = 1'b1;
      next_state_strobe_nxt = 1'b1;
      next_state_nxt = ST_IDLE;
    end
    else if (expired)
    begin
      rx_timer_running_nxt = 1'b0;
      if (!keep_rx)
      begin
        rx_timeout_exit_nxt = 1'b1;
        next_state_strobe_nxt = 1'b1;
        next_state_nxt = ST_IDLE;
      end
    end
    else if (rx_timer_running_r)
    begin
      timer_nxt = timer_r + TIMER_ONE;
    end
    if (radio_in.tx_packet_done && !next_state_strobe_nxt)
    begin
      next_state_strobe_nxt = 1'b1;
      case (after_tx)
        2'h0: next_state_nxt = ST_IDLE;
        2'h1: next_state_nxt = ST_SYNTH_ON_TX_READY;
        2'h2: next_state_nxt = ST_TX;
        default: next_state_nxt = ST_RX;
      endcase
      preamble_restart_nxt = (after_tx == 2'h2);
    end
  end

  // Clear channel indication formed from the live select field.
  always_comb
  begin
    case (cca_sel)
      2'h0: clear_channel_nxt = 1'b1;
      2'h1: clear_channel_nxt = radio_in.rssi_below;
      2'h2: clear_channel_nxt = !radio_in.receiving_packet;
      default: clear_channel_nxt = radio_in.rssi_below && !radio_in.receiving_packet;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      timer_r <= '0;
      limit_r <= '0;
      rx_timer_running_r <= 1'b0;
      next_state_r <= ST_IDLE;
      next_state_strobe_r <= 1'b0;
      rx_timeout_exit_r <= 1'b0;
      preamble_restart_r <= 1'b0;
      clear_channel_indication_r <= 1'b0;
    end
    else
    begin
      timer_r <= timer_nxt;
      limit_r <= limit_nxt;
      rx_timer_running_r <= rx_timer_running_nxt;
      next_state_r <= next_state_nxt;
      next_state_strobe_r <= next_state_strobe_nxt;
      rx_timeout_exit_r <= rx_timeout_exit_nxt;
      preamble_restart_r <= preamble_restart_nxt;
      clear_channel_indication_r <= clear_channel_nxt;
    end
  end

  // Checks on the outputs against their causes.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_cca_always: assert property (cca_sel == 2'h0 ##1 cca_sel == 2'h0 |-> clear_channel_indication_r)
    else $error("clear channel not set in always mode");
  // The expected indication is rebuilt from the mode table, not from the design's own next value.
  chk_cca_follows: assert property (##1 clear_channel_indication_r ==
                                    ($past(cca_sel) == 2'h0 ||
                                     ($past(cca_sel) == 2'h1 && $past(radio_in.rssi_below)) ||
                                     ($past(cca_sel) == 2'h2 && !$past(radio_in.receiving_packet)) ||
                                     ($past(cca_sel) == 2'h3 && $past(radio_in.rssi_below) &&
                                      !$past(radio_in.receiving_packet))))
    else $error("clear channel does not follow mode");
  chk_cca_receiving: assert property ($past(cca_sel) == 2'h3 && $past(radio_in.receiving_packet)
                                      |-> !clear_channel_indication_r)
    else $error("clear channel set while receiving");
  chk_rx_start_timer: assert property (radio_in.rx_enter |=> rx_timer_running_r && timer_r == '0)
    else $error("timer not started on receive entry");
  chk_rx_leave_stop: assert property (radio_in.rx_leave && !radio_in.rx_enter |=> !rx_timer_running_r)
    else $error("timer still running after leaving receive");
  chk_no_timeout_sel: assert property (rx_time_sel == RX_TIME_NONE && !radio_in.cs_valid
                                       |=> !rx_timeout_exit_r)
    else $error("timeout exit with timeout disabled");
  // A carrier-sense end in the same cycle outranks the timeout, so it is kept out of the antecedent.
  chk_timeout_keep: assert property (expired && keep_rx && !radio_in.cs_valid && !radio_in.rx_enter &&
                                     !radio_in.rx_leave && !radio_in.rx_packet_done |=> !rx_timeout_exit_r)
    else $error("left receive despite qualifier");
  chk_cs_end: assert property (rx_timer_running_r && rx_timeout_config_r[RX_END_CS_BIT] &&
                               radio_in.cs_valid && !radio_in.carrier_sense && !radio_in.rx_enter &&
                               !radio_in.rx_leave && !radio_in.rx_packet_done
                               |=> rx_timeout_exit_r && next_state_r == ST_IDLE)
    else $error("carrier sense end missed");
  chk_limit_value: assert property (radio_in.rx_enter |=> limit_r == $past(limit_calc) && limit_r != '0)
    else $error("timeout limit wrong");
  chk_after_rx: assert property (radio_in.rx_packet_done && !radio_in.rx_enter && !radio_in.rx_leave
                                 |=> next_state_strobe_r && next_state_r == radio_state_t'($past(after_rx)))
    else $error("wrong state after receive");
  chk_after_tx: assert property (radio_in.tx_packet_done && !radio_in.rx_packet_done &&
                                 !radio_in.cs_valid && !rx_timer_running_r
                                 |=> next_state_r == radio_state_t'($past(after_tx)))
    else $error("wrong state after transmit");
  chk_preamble_restart: assert property (preamble_restart_r |-> next_state_r == ST_TX && $past(after_tx) == 2'h2)
    else $error("preamble restart without stay in transmit");

  cov_timeout_exit: cover property (rx_timer_running_r ##1 rx_timeout_exit_r);
  cov_cs_exit: cover property (radio_in.cs_valid && rx_timeout_config_r[RX_END_CS_BIT] ##1 rx_timeout_exit_r);
  cov_preamble: cover property (preamble_restart_r);
  cov_stay_rx: cover property (radio_in.rx_packet_done && after_rx == 2'h3 ##1 next_state_r == ST_RX);
endmodule

/* design/rx_exit_pkg.sv */
// Package with register map, field layout, timing constants and types of the receive exit control.
package rx_exit_pkg;
  // Register offsets on the serial register port.
  localparam logic [5:0] RX_TIMEOUT_CONFIG_OFS = 6'h16;
  localparam logic [5:0] PACKET_EXIT_CCA_CONFIG_OFS = 6'h17;
  localparam logic [5:0] EXIT_STATUS_OFS = 6'h38;
  // Reset values.
  localparam logic [7:0] RX_TIMEOUT_CONFIG_RST = 8'h07;
  localparam logic [7:0] PACKET_EXIT_CCA_CONFIG_RST = 8'h30;
  // Field positions of the receive timeout register.
  localparam int RX_END_CS_BIT = 4;
  localparam int RX_QUAL_BIT = 3;
  localparam int RX_TIME_LSB = 0;
  localparam int RX_TIME_W = 3;
  localparam logic [7:0] RX_TIMEOUT_WMASK = 8'h1f;
  // Field positions of the exit and clear channel register.
  localparam int CCA_SEL_LSB = 4;
  localparam int AFTER_RX_LSB = 2;
  localparam int AFTER_TX_LSB = 0;
  localparam logic [7:0] PACKET_EXIT_WMASK = 8'h3f;
  // Timeout select value meaning no timeout.
  localparam logic [2:0] RX_TIME_NONE = 3'h7;
  // Timeout factor for select zero, resolution zero, in units of 0.0001 us.
  localparam int TIMEOUT_BASE_US_X10000 = 36058;
  localparam int CLK_MHZ = 10;
  localparam int SCALE_SHIFT = 10;
  // Cycles per wake period unit at factor 1, scaled by two to the SCALE_SHIFT.
  localparam logic [15:0] TIMEOUT_SCALE_Q =
    16'((TIMEOUT_BASE_US_X10000 * CLK_MHZ * (1 << SCALE_SHIFT)) / 10000);
  // Resolution multipliers relative to resolution zero.
  localparam logic [3:0] RES_MULT_0 = 4'h1;
  localparam logic [3:0] RES_MULT_1 = 4'h5;
  localparam logic [3:0] RES_MULT_2 = 4'h9;
  localparam logic [3:0] RES_MULT_3 = 4'hd;
  localparam int TIMER_W = 36;
  localparam logic [35:0] TIMER_ONE = 36'h1;
  // Radio states chosen after a packet.
  typedef enum logic [1:0] {ST_IDLE, ST_SYNTH_ON_TX_READY, ST_TX, ST_RX} radio_state_t;
  // Radio events and detector levels.
  typedef struct packed {
    logic rx_enter;
    logic rx_leave;
    logic rx_packet_done;
    logic tx_packet_done;
    logic cs_valid;
    logic carrier_sense;
    logic rssi_below;
    logic receiving_packet;
    logic sync_found;
    logic preamble_quality;
  } radio_in_t;
endpackage

/* test/radio_model.sv */
// Behavioural radio core that feeds detector pulses and levels to the exit control.
`timescale 1ns/100ps
module radio_model
  import rx_exit_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [4:0] ev_req,
  input wire logic [4:0] lv_req,
  output radio_in_t radio_in
);
  // Requests pass one flop, as the radio core's own outputs would; the bench holds an event one cycle.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      radio_in <= '0;
    end
    else
    begin
      radio_in <= radio_in_t'({ev_req, lv_req});
    end
  end
endmodule

/* test/tb_rx_exit_ctrl.sv */
// Self-checking bench for the receive exit control.
`timescale 1ns/100ps
module tb_rx_exit_ctrl
  import rx_exit_pkg::*;
;
  logic clk_sys, rst, reg_wr, reg_rd, cca, strobe, tmo_exit, restart, running;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_r;
  logic [15:0] wake_event_period;
  logic [1:0] wake_poll_resolution;
  logic [4:0] ev_req, lv_req;
  radio_in_t radio_in;
  radio_state_t next_state_r;
  int fails, checks, cycles, n;
  logic e;
  rx_exit_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .radio_in(radio_in), .wake_event_period(wake_event_period),
    .wake_poll_resolution(wake_poll_resolution), .clear_channel_indication_r(cca), .next_state_r(next_state_r),
    .next_state_strobe_r(strobe), .rx_timeout_exit_r(tmo_exit), .preamble_restart_r(restart),
    .rx_timer_running_r(running));
  radio_model i_radio (.clk_sys(clk_sys), .rst(rst), .ev_req(ev_req), .lv_req(lv_req), .radio_in(radio_in));
  // Clock of 100 ns period.
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Watchdog against a hung run.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk8(reg_rdata_r, exp);
  endtask
  // Event bits: enter, leave, rx done, tx done, cs valid. Level bits: carrier, below, receiving, sync, quality.
  task automatic radio(input logic [4:0] ev, input logic [4:0] lv);
    @(posedge clk_sys);
    ev_req <= ev;
    lv_req <= lv;
    @(posedge clk_sys);
    ev_req <= 5'h00;
    @(posedge clk_sys);
    #1;
  endtask
  // Counts cycles until the exit pulse, or until the bound runs out.
  task automatic wait_exit(input int bound);
    n = 0;
    while (tmo_exit !== 1'b1 && n < bound)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  // One receive entry with the given period, resolution and levels; checks the cycles to the timeout exit.
  task automatic tmo_len(input logic [15:0] per, input logic [1:0] res, input logic [4:0] lv, input int exp);
    @(posedge clk_sys);
    wake_event_period <= per;
    wake_poll_resolution <= res;
    radio(5'h10, lv);
    wait_exit(exp + 20);
    chk1(n >= exp - 1 && n <= exp + 3, 1'b1);
  endtask
  // Main sequence.
  initial
  begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, ev_req, lv_req} = '1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, ev_req, lv_req} = '0;
    wake_event_period = 16'h03e8;
    wake_poll_resolution = 2'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(RX_TIMEOUT_CONFIG_OFS, 8'h07);
    rd(PACKET_EXIT_CCA_CONFIG_OFS, 8'h30);
    rd(6'h20, 8'h00);
    wr(RX_TIMEOUT_CONFIG_OFS, 8'hff);
    rd(RX_TIMEOUT_CONFIG_OFS, 8'h1f);
    // Clear channel modes against all level pairs; after-receive stays idle here, as the host must.
    for (int m = 0; m < 4; m++)
    begin
      wr(PACKET_EXIT_CCA_CONFIG_OFS, 8'(m << 4));
      for (int c = 0; c < 4; c++)
      begin
        radio(5'h00, {1'b0, c[0], c[1], 2'b00});
        e = (m == 0) || (m == 1 && c[0]) || (m == 2 && !c[1]) || (m == 3 && c[0] && !c[1]);
        chk1(cca, e);
        rd(EXIT_STATUS_OFS, {5'h00, e, 2'h0});
      end
    end
    wr(RX_TIMEOUT_CONFIG_OFS, 8'h07);
    for (int s = 0; s < 4; s++)
    begin
      wr(PACKET_EXIT_CCA_CONFIG_OFS, 8'(s << 2));
      radio(5'h10, 5'h00);
      radio(5'h04, 5'h00);
      chk1(strobe, 1'b1);
      chk8({6'h00, next_state_r}, 8'(s));
      radio(5'h08, 5'h00);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(PACKET_EXIT_CCA_CONFIG_OFS, 8'(s));
      radio(5'h02, 5'h00);
      chk8({6'h00, next_state_r}, 8'(s));
      chk1(restart, s == 2);
    end
    // No timeout with select seven; leaving by other means stops the timer.
    radio(5'h10, 5'h00);
    wait_exit(700);
    chk1(tmo_exit, 1'b0);
    chk1(running, 1'b1);
    radio(5'h08, 5'h00);
    chk1(running, 1'b0);
    // Limit in cycles is period times factor times ten at 10 MHz, for every resolution and two selects.
    wr(RX_TIMEOUT_CONFIG_OFS, 8'h06);
    tmo_len(16'h03e8, 2'h0, 5'h00, 563);
    chk8({6'h00, next_state_r}, 8'h00);
    tmo_len(16'h03e8, 2'h3, 5'h00, 7324);
    tmo_len(16'h0064, 2'h1, 5'h00, 281);
    tmo_len(16'h0064, 2'h2, 5'h00, 507);
    wr(RX_TIMEOUT_CONFIG_OFS, 8'h00);
    tmo_len(16'h000a, 2'h0, 5'h00, 360);
    // Qualifier clear: preamble quality alone does not hold receive, a sync word does.
    wr(RX_TIMEOUT_CONFIG_OFS, 8'h06);
    tmo_len(16'h03e8, 2'h0, 5'h01, 563);
    radio(5'h10, 5'h02);
    wait_exit(700);
    chk1(tmo_exit, 1'b0);
    chk1(running, 1'b0);
    // Preamble quality keeps receiving when the qualifier is set.
    wr(RX_TIMEOUT_CONFIG_OFS, 8'h0e);
    radio(5'h10, 5'h01);
    wait_exit(700);
    chk1(tmo_exit, 1'b0);
    chk1(running, 1'b0);
    // Carrier sense above threshold keeps receiving; below it ends receive at once.
    wr(RX_TIMEOUT_CONFIG_OFS, 8'h16);
    radio(5'h10, 5'h00);
    radio(5'h01, 5'h10);
    chk1(tmo_exit, 1'b0);
    radio(5'h01, 5'h00);
    chk1(tmo_exit, 1'b1);
    chk1(running, 1'b0);
    tally_and_finish();
  end
endmodule
